//--- verilog/dsf_pkg.sv
// Package of constants and types for the diagnostic status flag register
package dsf_pkg;
    // ****************************************************************
    // Register layout
    // ****************************************************************
    localparam int          STAT_W      = 16;
    localparam logic [15:0] STAT_RESET  = 16'h0000;
    localparam int          BIT_ACC_Z   = 15;
    localparam int          BIT_ACC_Y   = 14;
    localparam int          BIT_ACC_X   = 13;
    localparam int          BIT_GYR_Z   = 12;
    localparam int          BIT_GYR_Y   = 11;
    localparam int          BIT_GYR_X   = 10;
    localparam int          BIT_ALARM2  = 9;
    localparam int          BIT_ALARM1  = 8;
    localparam int          BIT_UNUSED  = 7;
    localparam int          BIT_FLASH   = 6;
    localparam int          BIT_ST_SUM  = 5;
    localparam int          BIT_SPI_ERR = 3;
    localparam int          ST_LSB      = 10;
    localparam int          AL_LSB      = 8;
    // Bits this block may ever set
    localparam logic [15:0] STAT_MASK   = 16'hFF68;

    // ****************************************************************
    // Link framing
    // ****************************************************************
    localparam int          WORD_BITS   = 16;
    localparam int          CNT_W       = 4;
    localparam logic [3:0]  CNT_RESET   = 4'h0;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [5:0] st_fail;    // Acc Z,Y,X then gyro Z,Y,X
        logic [1:0] alarm;      // Alarm 2, alarm 1
        logic       flash_fail;
    } dsf_cond_t;
endpackage : dsf_pkg

//--- verilog/dsf_diag_status.sv
// Diagnostic status flag register with serial framing check
`timescale 1ns/1ps
`default_nettype none
module dsf_diag_status (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               sclk,
    input  wire logic               cs_n,
    input  wire logic               sample_tick,
    input  wire logic               st_done,
    input  wire dsf_pkg::dsf_cond_t cond,
    input  wire logic               rd_strobe,
    output logic [15:0]             status_ff,
    output logic [15:0]             rd_data_ff
);
    // ****************************************************************
    // Link domain: free edge count, Gray coded
    // ****************************************************************
    // Never cleared per frame: the link clock stops between frames, so
    // the main domain compares counts across frame boundaries instead.
    logic [3:0] bin_ff;
    logic [3:0] gray_ff;
    logic [3:0] nxt_bin;

    assign nxt_bin = bin_ff + 4'h1;

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            bin_ff  <= dsf_pkg::CNT_RESET;
            gray_ff <= dsf_pkg::CNT_RESET;
        end else begin
            bin_ff  <= nxt_bin;
            gray_ff <= nxt_bin ^ (nxt_bin >> 1);
        end
    end

    // ****************************************************************
    // Crossings into the main domain
    // ****************************************************************
    logic [3:0] gray_s1_ff;
    logic [3:0] gray_s2_ff;
    logic       cs_s1_ff;
    logic       cs_s2_ff;
    logic       cs_d_ff;
    logic [3:0] frame_start_ff;
    logic       frame_end;
    logic       frame_bad;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gray_s1_ff <= dsf_pkg::CNT_RESET;
            gray_s2_ff <= dsf_pkg::CNT_RESET;
            cs_s1_ff   <= 1'h1;
            cs_s2_ff   <= 1'h1;
            cs_d_ff    <= 1'h1;
        end else begin
            gray_s1_ff <= gray_ff;
            gray_s2_ff <= gray_s1_ff;
            cs_s1_ff   <= cs_n;
            cs_s2_ff   <= cs_s1_ff;
            cs_d_ff    <= cs_s2_ff;
        end
    end

    // Rising chip select ends a frame; count snapshot taken there too
    assign frame_end = cs_s2_ff & ~cs_d_ff;
    // Equal Gray values mean a whole number of 16-edge words
    assign frame_bad = frame_end && (gray_s2_ff != frame_start_ff);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frame_start_ff <= dsf_pkg::CNT_RESET;
        end else if (frame_end) begin
            frame_start_ff <= gray_s2_ff;
        end
    end

    // ****************************************************************
    // Flag sets and read-clear
    // ****************************************************************
    logic [15:0] set_vec;
    logic [15:0] nxt_status;

    always_comb begin
        set_vec = 16'h0000;
        // Self-test bits follow st_done too; alarms and flash only ticks
        if (sample_tick || st_done) begin
            set_vec[dsf_pkg::BIT_ACC_Z:dsf_pkg::ST_LSB] =
                cond.st_fail;
            set_vec[dsf_pkg::BIT_ST_SUM] = |cond.st_fail;
        end
        if (sample_tick) begin
            set_vec[dsf_pkg::BIT_ALARM2:dsf_pkg::AL_LSB] =
                cond.alarm;
            set_vec[dsf_pkg::BIT_FLASH] = cond.flash_fail;
        end
        set_vec[dsf_pkg::BIT_SPI_ERR] = frame_bad;
        set_vec = set_vec & dsf_pkg::STAT_MASK;
        // A set arriving with the read survives the clear
        if (rd_strobe) begin
            nxt_status = set_vec;
        end else begin
            nxt_status = status_ff | set_vec;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_ff <= dsf_pkg::STAT_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= dsf_pkg::STAT_RESET;
        end else if (rd_strobe) begin
            rd_data_ff <= status_ff;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence read_s;
        rd_strobe ##0 (set_vec == 16'h0000);
    endsequence

    clear_on_read_a: assert property (
        read_s |=> (status_ff == 16'h0000))
        else $error("flags not cleared by read");
    read_data_a: assert property (
        rd_strobe |=> (rd_data_ff == $past(status_ff)))
        else $error("read data not the flags before clear");
    sticky_hold_a: assert property (
        !rd_strobe |=> ((status_ff & $past(status_ff)) == $past(status_ff)))
        else $error("flag dropped without read");
    unused_zero_a: assert property (
        (status_ff[dsf_pkg::BIT_UNUSED] == 1'b0) && (status_ff[4] == 1'b0))
        else $error("unused bit set");
    frame_error_a: assert property (
        frame_end && (gray_s2_ff != frame_start_ff)
        |=> status_ff[dsf_pkg::BIT_SPI_ERR])
        else $error("framing error not flagged");
    acc_fail_a: assert property (
        st_done && cond.st_fail[5]
        |=> status_ff[dsf_pkg::BIT_ACC_Z] && status_ff[dsf_pkg::BIT_ST_SUM])
        else $error("accelerometer self-test failure lost");
    gyro_fail_a: assert property (
        st_done && cond.st_fail[0] |=> status_ff[dsf_pkg::BIT_GYR_X])
        else $error("gyroscope self-test failure lost");
    alarm_reset_a: assert property (
        rd_strobe ##1 (sample_tick && cond.alarm[1])
        |=> status_ff[dsf_pkg::BIT_ALARM2])
        else $error("alarm not restored after clearing read");
    flash_fail_a: assert property (
        sample_tick && cond.flash_fail |=> status_ff[dsf_pkg::BIT_FLASH])
        else $error("flash checksum failure not flagged");

    // ****************************************************************
    // Holds, per-bit sets and the framing snapshot
    // ****************************************************************
    // Cycle with no set source and no read
    sequence quiet_s;
        !sample_tick && !st_done && !frame_bad && !rd_strobe;
    endsequence

    // Read followed at once by a sample tick
    sequence tick_after_read_s;
        rd_strobe ##1 sample_tick;
    endsequence

    no_stray_set_a: assert property (
        quiet_s |=> (status_ff == $past(status_ff)))
        else $error("flag changed with no set source");
    reserved_low_a: assert property (
        status_ff[2:0] == 3'h0)
        else $error("reserved low bits set");
    alarm1_set_a: assert property (
        sample_tick && cond.alarm[0] |=> status_ff[dsf_pkg::BIT_ALARM1])
        else $error("alarm 1 not flagged");
    acc_y_set_a: assert property (
        sample_tick && cond.st_fail[4] |=> status_ff[dsf_pkg::BIT_ACC_Y])
        else $error("Y accelerometer failure not flagged");
    gyro_z_set_a: assert property (
        (sample_tick || st_done) && cond.st_fail[2]
        |=> status_ff[dsf_pkg::BIT_GYR_Z])
        else $error("Z gyroscope failure not flagged");
    summary_bit_a: assert property (
        (|status_ff[dsf_pkg::BIT_ACC_Z:dsf_pkg::ST_LSB])
        |-> status_ff[dsf_pkg::BIT_ST_SUM])
        else $error("sensor failure without summary bit");
    persist_set_a: assert property (
        tick_after_read_s ##0 cond.st_fail[5]
        |=> status_ff[dsf_pkg::BIT_ACC_Z])
        else $error("persisting failure not restored");
    rd_data_hold_a: assert property (
        !rd_strobe |=> $stable(rd_data_ff))
        else $error("read data changed without a read");
    spi_clear_a: assert property (
        rd_strobe && !frame_bad |=> !status_ff[dsf_pkg::BIT_SPI_ERR])
        else $error("framing flag not cleared by read");
    frame_ok_a: assert property (
        frame_end && (gray_s2_ff == frame_start_ff) && !rd_strobe
        |=> (status_ff[dsf_pkg::BIT_SPI_ERR] ==
             $past(status_ff[dsf_pkg::BIT_SPI_ERR])))
        else $error("framing flag set on a whole frame");
    frame_snap_a: assert property (
        frame_end |=> (frame_start_ff == $past(gray_s2_ff)))
        else $error("frame count snapshot not taken");
endmodule : dsf_diag_status
`default_nettype wire

//--- verif/dsf_host_model.sv
// Host serial controller model that frames chip-select and serial clock
`timescale 1ns/1ps
`default_nettype none
module dsf_host_model (
    input  wire logic       go,
    input  wire logic [5:0] n_edges,
    output logic            sclk,
    output logic            cs_n
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // Clock only inside frames; long tail lets the edge count settle
    always @(posedge go) begin
        cs_n = 1'b0;
        #43;
        repeat (n_edges) begin
            sclk = 1'b1;
            #7.5;
            sclk = 1'b0;
            #7.5;
        end
        #400;
        cs_n = 1'b1;
    end
endmodule : dsf_host_model
`default_nettype wire

//--- verif/dsf_diag_status_tb_top.sv
// Self-checking bench for the diagnostic status flag register
`timescale 1ns/1ps
`default_nettype none
module dsf_diag_status_tb_top;
    logic mclk = 0, rst = 1, sample_tick = 0, st_done = 0, rd_strobe = 0;
    logic go = 0, sclk, cs_n;
    logic [5:0] n_edges = 6'h00;
    logic [15:0] status_ff, rd_data_ff;
    dsf_pkg::dsf_cond_t cond = '0;
    int fail_count = 0, n_compared = 0, cycles = 0;
    always #50 mclk = ~mclk;
    dsf_host_model i_host (.go(go), .n_edges(n_edges), .sclk(sclk),
        .cs_n(cs_n));
    dsf_diag_status i_dut (.mclk(mclk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .sample_tick(sample_tick), .st_done(st_done), .cond(cond),
        .rd_strobe(rd_strobe), .status_ff(status_ff), .rd_data_ff(rd_data_ff));
    // ****************************************************************
    // Helpers
    // ****************************************************************
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] flags(dsf_pkg::dsf_cond_t c);
        return {c.st_fail, c.alarm, 1'b0, c.flash_fail, |c.st_fail, 5'h00};
    endfunction : flags
    task cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task do_read;
        rd_strobe = 1'b1;
        cyc(1);
        rd_strobe = 1'b0;
    endtask : do_read
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_bits;
        dsf_pkg::dsf_cond_t c;
        for (int i = 0; i < 9; i++) begin
            c = 9'h001 << i;
            cond = c;
            sample_tick = 1'b1;
            cyc(1);
            sample_tick = 1'b0;
            cond = '0;
            check(status_ff, flags(c));
            do_read;
            check(rd_data_ff, flags(c));
            check(status_ff, 16'h0000);
        end
        $display("bit map test done");
    endtask : t_bits
    task t_persist;
        cond = 9'h1FF;
        sample_tick = 1'b1;
        cyc(1);
        sample_tick = 1'b0;
        rd_strobe = 1'b1;
        cyc(1);
        check(status_ff, 16'h0000);
        check(rd_data_ff, 16'hFF60);
        // Strobe held high: second read meets the next tick
        sample_tick = 1'b1;
        cyc(1);
        rd_strobe = 1'b0;
        sample_tick = 1'b0;
        check(status_ff, 16'hFF60);
        check(rd_data_ff, 16'h0000);
        cond = '0;
        cyc(1);
        do_read;
        $display("persist test done");
    endtask : t_persist
    task t_selftest;
        cond = 9'h157;
        st_done = 1'b1;
        cyc(1);
        st_done = 1'b0;
        cond = '0;
        check(status_ff, 16'hA820);
        do_read;
        cond = 9'h0AF;
        st_done = 1'b1;
        cyc(1);
        st_done = 1'b0;
        cond = '0;
        check(status_ff, 16'h5420);
        do_read;
        $display("self-test summary test done");
    endtask : t_selftest
    task t_frame(input logic [5:0] n, input logic [15:0] exp);
        n_edges = n;
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(14);
        check(status_ff, exp);
        do_read;
        $display("frame test with %0d edges done", n);
    endtask : t_frame
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            summarize;
        end
    end
    initial begin
        cyc(12);
        check(status_ff, 16'h0000);
        check(rd_data_ff, 16'h0000);
        rst = 1'b0;
        t_bits;
        t_persist;
        t_selftest;
        // Running totals 16, 31, 48, 80 give steps 16, 15, 17, 32
        t_frame(6'h10, 16'h0000);
        t_frame(6'h0F, 16'h0008);
        t_frame(6'h11, 16'h0008);
        t_frame(6'h20, 16'h0000);
        summarize;
    end
endmodule : dsf_diag_status_tb_top
`default_nettype wire
